// File: verilog/prox_pkg.sv
/*
 * Constants shared by the proximity/light threshold and persistence block:
 * register offsets, reset values, field positions and timing counts.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none

package prox_pkg;

   // register offsets
   localparam logic [7:0] ADDR_PHT_LO = 8'h8A;
   localparam logic [7:0] ADDR_PHT_HI = 8'h8B;
   localparam logic [7:0] ADDR_PERSISTENCE_FILTERS   = 8'h8C;
   localparam logic [7:0] ADDR_GENERAL_CONFIG_ZERO   = 8'h8D;

   // reset values (general_config_zero reserved 7:3 = 01000)
   localparam logic [7:0] RST_PHT_LO = 8'h00;
   localparam logic [7:0] RST_PHT_HI = 8'h00;
   localparam logic [7:0] RST_PERSISTENCE_FILTERS   = 8'h00;
   localparam logic [7:0] RST_GENERAL_CONFIG_ZERO   = 8'h40;
   localparam logic [7:0] RD_NONE    = 8'h00;

   // field positions
   localparam int PERSISTENCE_FILTERS_PROX_MSB  = 7;
   localparam int PERSISTENCE_FILTERS_PROX_LSB  = 4;
   localparam int PERSISTENCE_FILTERS_LIGHT_MSB = 3;
   localparam int PERSISTENCE_FILTERS_LIGHT_LSB = 0;
   localparam int GENERAL_CONFIG_ZERO_WAIT_X12_ENABLE_BIT = 2;
   localparam int GENERAL_CONFIG_ZERO_X16_BIT   = 0;
   localparam int HI_BITS_MSB    = 5;
   localparam int HI_RSVD_MSB    = 7;

   // data widths and the 8-bit compare window of a 10-bit result
   localparam int PROX_W      = 14;
   localparam int LIGHT_W     = 16;
   localparam int PROX10_MSB  = 9;
   localparam int PROX10_LSB  = 2;

   // light persistence decode
   localparam logic [3:0] LIGHT_DIRECT_MAX = 4'h3;
   localparam logic [5:0] LIGHT_STEP       = 6'h05;

   // multipliers
   localparam logic [11:0] WAIT_MULT_LONG  = 12'h00C;
   localparam int          PULSE_X16_SHIFT = 4;

   // timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int WAIT_TICK_NS   = 2780000;  // 2.78 ms
   localparam int WAIT_TICK_CYC  = WAIT_TICK_NS / CLK_PERIOD_NS;
   localparam int PULSE_BASE_NS  = 4000;     // 4 us
   localparam int PULSE_BASE_CYC = PULSE_BASE_NS / CLK_PERIOD_NS;

   typedef enum logic {WAIT_IDLE, WAIT_RUN} wait_state_e;

endpackage

`default_nettype wire

// File: verilog/prox_thresh_persist.sv
/*
 * Proximity high threshold, persistence filters, interrupt flags and pin,
 * general_config_zero wait-long timer and emitter pulse stretcher.
 * Assumes the serial register port is decoded outside into single-cycle
 * read and write strobes; results arrive with a one-cycle valid strobe.
 */
`default_nettype none

module prox_thresh_persist #(
   parameter int WAIT_TICK_CYC = prox_pkg::WAIT_TICK_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        auto_pulse_off,
   input  wire logic        prox_valid,
   input  wire logic [13:0] prox_result,
   input  wire logic [13:0] prox_lo_thresh,
   input  wire logic        light_valid,
   input  wire logic [15:0] light_result,
   input  wire logic [15:0] light_lo_thresh,
   input  wire logic [15:0] light_hi_thresh,
   input  wire logic        prox_irq_enable,
   input  wire logic        light_irq_enable,
   input  wire logic        prox_irq_clear,
   input  wire logic        light_irq_clear,
   output logic             prox_irq_flag,
   output logic             light_irq_flag,
   output logic             int_n,
   input  wire logic [7:0]  wait_period_count,
   input  wire logic        wait_start,
   output logic             wait_done,
   input  wire logic [1:0]  emitter_pulse_length,
   input  wire logic        pulse_start,
   output logic             emitter_on
);

   logic [7:0]  pht_lo_r;
   logic [7:0]  pht_hi_r;
   logic [7:0]  shadow_r;
   logic [13:0] pht_active_r;
   logic [7:0]  persistence_filters_r;
   logic [7:0]  general_config_zero_r;
   logic [7:0]  rdata_nxt;
   logic [3:0]  prox_tgt;
   logic [5:0]  light_tgt;
   logic [3:0]  prox_cnt_r;
   logic [3:0]  prox_cnt_nxt;
   logic [5:0]  light_cnt_r;
   logic [5:0]  light_cnt_nxt;
   logic        prox_out;
   logic        light_out;
   logic        prox_fire;
   logic        light_fire;
   logic        prox_flag_nxt;
   logic        light_flag_nxt;
   logic        prox_flag_r;
   logic        light_flag_r;
   logic        int_r;
   logic [7:0]  prox10;
   logic        wr_hi;

   // light persistence code to result count
   function automatic logic [5:0] light_count(input logic [3:0] code);
      logic [5:0] steps;
      steps = {2'h0, code - prox_pkg::LIGHT_DIRECT_MAX};
      if (code <= prox_pkg::LIGHT_DIRECT_MAX) begin
         light_count = {2'h0, code};
      end else begin
         light_count = 6'(steps * prox_pkg::LIGHT_STEP);
      end
   endfunction

   assign wr_hi = reg_wr && (reg_addr == prox_pkg::ADDR_PHT_HI);

   // register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pht_lo_r <= prox_pkg::RST_PHT_LO;
         pht_hi_r <= prox_pkg::RST_PHT_HI;
         persistence_filters_r   <= prox_pkg::RST_PERSISTENCE_FILTERS;
         general_config_zero_r   <= prox_pkg::RST_GENERAL_CONFIG_ZERO;
      end else if (reg_wr) begin
         case (reg_addr)
            prox_pkg::ADDR_PHT_LO: pht_lo_r <= reg_wdata;
            prox_pkg::ADDR_PHT_HI: pht_hi_r <= reg_wdata;
            prox_pkg::ADDR_PERSISTENCE_FILTERS:   persistence_filters_r   <= reg_wdata;
            prox_pkg::ADDR_GENERAL_CONFIG_ZERO:   general_config_zero_r   <= reg_wdata;
            default: ;
         endcase
      end
   end

   // low byte waits in a shadow until the upper byte lands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_r     <= prox_pkg::RST_PHT_LO;
         pht_active_r <= {prox_pkg::RST_PHT_HI[prox_pkg::HI_BITS_MSB:0],
                          prox_pkg::RST_PHT_LO};
      end else begin
         if (reg_wr && reg_addr == prox_pkg::ADDR_PHT_LO) begin
            shadow_r <= reg_wdata;
         end
         if (wr_hi) begin
            pht_active_r <= {reg_wdata[prox_pkg::HI_BITS_MSB:0],
                             shadow_r};
         end
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      case (reg_addr)
         prox_pkg::ADDR_PHT_LO: rdata_nxt = pht_lo_r;
         prox_pkg::ADDR_PHT_HI: rdata_nxt = pht_hi_r;
         prox_pkg::ADDR_PERSISTENCE_FILTERS:   rdata_nxt = persistence_filters_r;
         prox_pkg::ADDR_GENERAL_CONFIG_ZERO:   rdata_nxt = general_config_zero_r;
         default:               rdata_nxt = prox_pkg::RD_NONE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= prox_pkg::RD_NONE;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // range compare, 14-bit or top eight of a 10-bit result
   assign prox10 = prox_result[prox_pkg::PROX10_MSB:prox_pkg::PROX10_LSB];
   always_comb begin
      if (auto_pulse_off) begin
         prox_out = (prox10 > pht_active_r[7:0]) ||
                    (prox10 < prox_lo_thresh[7:0]);
      end else begin
         prox_out = (prox_result > pht_active_r) ||
                    (prox_result < prox_lo_thresh);
      end
   end
   assign light_out = (light_result > light_hi_thresh) ||
                      (light_result < light_lo_thresh);

   // persistence settings
   assign prox_tgt  = persistence_filters_r[prox_pkg::PERSISTENCE_FILTERS_PROX_MSB:prox_pkg::PERSISTENCE_FILTERS_PROX_LSB];
   assign light_tgt = light_count(
             persistence_filters_r[prox_pkg::PERSISTENCE_FILTERS_LIGHT_MSB:prox_pkg::PERSISTENCE_FILTERS_LIGHT_LSB]);

   // consecutive counters, saturating at the setting
   always_comb begin
      prox_cnt_nxt = prox_cnt_r;
      if (prox_valid) begin
         if (!prox_out) begin
            prox_cnt_nxt = '0;
         end else if (prox_cnt_r < prox_tgt) begin
            prox_cnt_nxt = prox_cnt_r + 4'h1;
         end else begin
            prox_cnt_nxt = prox_tgt;
         end
      end
   end

   always_comb begin
      light_cnt_nxt = light_cnt_r;
      if (light_valid) begin
         if (!light_out) begin
            light_cnt_nxt = '0;
         end else if (light_cnt_r < light_tgt) begin
            light_cnt_nxt = light_cnt_r + 6'h01;
         end else begin
            light_cnt_nxt = light_tgt;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prox_cnt_r  <= '0;
         light_cnt_r <= '0;
      end else begin
         prox_cnt_r  <= prox_cnt_nxt;
         light_cnt_r <= light_cnt_nxt;
      end
   end

   // interrupt events: setting 0 fires on every result
   assign prox_fire  = prox_valid && ((prox_tgt == '0) ||
                       (prox_out && prox_cnt_nxt == prox_tgt));
   assign light_fire = light_valid && ((light_tgt == '0) ||
                       (light_out && light_cnt_nxt == light_tgt));

   // sticky flags, a new event beats a clear
   assign prox_flag_nxt  = prox_fire ||
                           (prox_flag_r && !prox_irq_clear);
   assign light_flag_nxt = light_fire ||
                           (light_flag_r && !light_irq_clear);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prox_flag_r  <= 1'b0;
         light_flag_r <= 1'b0;
         int_r        <= 1'b0;
      end else begin
         prox_flag_r  <= prox_flag_nxt;
         light_flag_r <= light_flag_nxt;
         int_r        <= (prox_flag_nxt && prox_irq_enable) ||
                         (light_flag_nxt && light_irq_enable);
      end
   end

   assign prox_irq_flag  = prox_flag_r;
   assign light_irq_flag = light_flag_r;
   assign int_n          = !int_r;

   // wait timer: increments of one tick, times twelve when long
   prox_pkg::wait_state_e wait_st_r;
   logic [11:0]           wait_left_r;
   logic [11:0]           wait_total;
   logic [31:0]           wait_sub_r;
   logic                  wait_done_r;
   assign wait_total = general_config_zero_r[prox_pkg::GENERAL_CONFIG_ZERO_WAIT_X12_ENABLE_BIT] ?
          12'(({4'h0, wait_period_count} + 12'h001) *
              prox_pkg::WAIT_MULT_LONG) :
          ({4'h0, wait_period_count} + 12'h001);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_st_r   <= prox_pkg::WAIT_IDLE;
         wait_left_r <= '0;
         wait_sub_r  <= '0;
         wait_done_r <= 1'b0;
      end else begin
         wait_done_r <= 1'b0;
         case (wait_st_r)
            prox_pkg::WAIT_IDLE: begin
               if (wait_start) begin
                  wait_left_r <= wait_total;
                  wait_sub_r  <= 32'(WAIT_TICK_CYC - 1);
                  wait_st_r   <= prox_pkg::WAIT_RUN;
               end
            end
            prox_pkg::WAIT_RUN: begin
               if (wait_sub_r != '0) begin
                  wait_sub_r <= wait_sub_r - 32'h1;
               end else if (wait_left_r == 12'h001) begin
                  wait_left_r <= '0;
                  wait_done_r <= 1'b1;
                  wait_st_r   <= prox_pkg::WAIT_IDLE;
               end else begin
                  wait_left_r <= wait_left_r - 12'h001;
                  wait_sub_r  <= 32'(WAIT_TICK_CYC - 1);
               end
            end
            default: wait_st_r <= prox_pkg::WAIT_IDLE;
         endcase
      end
   end
   assign wait_done = wait_done_r;

   // emitter pulse: base doubles per length code, x16 when set
   logic [15:0] pulse_len;
   logic [15:0] pulse_left_r;
   logic        emitter_r;
   assign pulse_len = general_config_zero_r[prox_pkg::GENERAL_CONFIG_ZERO_X16_BIT] ?
      16'(prox_pkg::PULSE_BASE_CYC << (emitter_pulse_length +
          prox_pkg::PULSE_X16_SHIFT)) :
      16'(prox_pkg::PULSE_BASE_CYC << emitter_pulse_length);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_left_r <= '0;
         emitter_r    <= 1'b0;
      end else if (!emitter_r && pulse_start) begin
         pulse_left_r <= pulse_len - 16'h0001;
         emitter_r    <= 1'b1;
      end else if (emitter_r) begin
         if (pulse_left_r == '0) begin
            emitter_r <= 1'b0;
         end else begin
            pulse_left_r <= pulse_left_r - 16'h0001;
         end
      end
   end

   assign emitter_on = emitter_r;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_lo_then_hi;
      reg_wr && reg_addr == prox_pkg::ADDR_PHT_LO ##1 wr_hi;
   endsequence
   sequence s_wait_load;
      wait_st_r == prox_pkg::WAIT_IDLE && wait_start;
   endsequence

   a_thresh_commit: assert property (
      s_lo_then_hi |=> pht_active_r ==
         {$past(reg_wdata[prox_pkg::HI_BITS_MSB:0]), $past(reg_wdata, 2)})
      else $error("threshold pair not committed together");
   a_shadow_hold: assert property (
      (reg_wr && reg_addr == prox_pkg::ADDR_PHT_LO) |=> $stable(pht_active_r))
      else $error("active threshold moved on low byte write");
   a_prox_clear: assert property (
      (prox_valid && !prox_out) |=> prox_cnt_r == 4'h0)
      else $error("prox counter not cleared in range");
   a_prox_count: assert property (
      (prox_valid && prox_out && prox_cnt_r < prox_tgt && !reg_wr)
         |=> prox_cnt_r == $past(prox_cnt_r) + 4'h1)
      else $error("prox counter did not advance");
   a_prox_sat: assert property (
      (prox_cnt_r == prox_tgt && !reg_wr) |=> prox_cnt_r <= prox_tgt)
      else $error("prox counter wrapped past setting");
   a_prox_flag: assert property (
      prox_fire |=> prox_irq_flag)
      else $error("prox flag missed an event");
   a_prox_every: assert property (
      (prox_valid && prox_tgt == 4'h0) |=> prox_irq_flag)
      else $error("setting zero did not flag every result");
   a_light_clear: assert property (
      (light_valid && !light_out) |=> light_cnt_r == 6'h00)
      else $error("light counter not cleared in range");
   a_light_code: assert property (
      (persistence_filters_r[prox_pkg::PERSISTENCE_FILTERS_LIGHT_MSB:prox_pkg::PERSISTENCE_FILTERS_LIGHT_LSB] == 4'hF)
         |-> light_tgt == 6'h3C)
      else $error("light code fifteen not sixty results");
   a_int_pin: assert property (
      ($rose(prox_irq_flag) && $past(prox_irq_enable)) |-> !int_n)
      else $error("interrupt pin not active with prox flag");
   a_wait_long: assert property (
      s_wait_load ##0 general_config_zero_r[prox_pkg::GENERAL_CONFIG_ZERO_WAIT_X12_ENABLE_BIT]
         |=> wait_left_r == 12'(($past(wait_period_count) + 1) * 12))
      else $error("wait long did not scale by twelve");
   a_pulse_x16: assert property (
      (!emitter_r && pulse_start && general_config_zero_r[prox_pkg::GENERAL_CONFIG_ZERO_X16_BIT])
         |=> emitter_on && pulse_left_r == 16'(
             (prox_pkg::PULSE_BASE_CYC * 16 <<
              $past(emitter_pulse_length)) - 1))
      else $error("x16 pulse length wrong");

endmodule

`default_nettype wire

// File: tb/host_model.sv
/*
 * Host processor model: register writes and reads over the block's
 * single-cycle strobe port.
 * Assumes the bench supplies sys_clk and calls the tasks hierarchically.
 */
`default_nettype none

module host_model (
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end

   // one write; released lines show inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // low byte then upper bits on the very next edge
   task automatic wr_thresh(input logic [7:0] lo, input logic [5:0] hi);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= prox_pkg::ADDR_PHT_LO;
      reg_wdata <= lo;
      @(posedge sys_clk);
      reg_addr <= prox_pkg::ADDR_PHT_HI;
      reg_wdata <= {2'b00, hi};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= {2'b11, ~hi};
   endtask

   // config write with reserved bits at default
   task automatic wr_general_config_zero(input logic wl, input logic x16);
      wr(prox_pkg::ADDR_GENERAL_CONFIG_ZERO, {5'b01000, wl, 1'b0, x16});
   endtask

   // one read, data taken after the answering edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// File: tb/proximity_als_threshold_persistence_tb.sv
/*
 * Self-checking bench for the threshold and persistence block.
 * Assumes prox_pkg and host_model are compiled first.
 */
`default_nettype none

module proximity_als_threshold_persistence_tb;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int TICK  = 2;
   localparam int LIMIT = 40000;

   logic        sys_clk, rst_n, reg_wr, reg_rd, auto_pulse_off;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, wait_period_count, d;
   logic        prox_valid, light_valid, prox_irq_clear, light_irq_clear;
   logic [13:0] prox_result, prox_lo_thresh;
   logic [15:0] light_result, light_lo_thresh, light_hi_thresh;
   logic        prox_irq_flag, light_irq_flag, int_n, wait_start;
   logic        wait_done, pulse_start, emitter_on;
   logic [1:0]  emitter_pulse_length;
   logic        prox_irq_enable, light_irq_enable;
   int          err_total, checks, cyc, k, w;

   prox_thresh_persist #(.WAIT_TICK_CYC(TICK)) u_prox_thresh_persist (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .auto_pulse_off(auto_pulse_off),
      .prox_valid(prox_valid), .prox_result(prox_result),
      .prox_lo_thresh(prox_lo_thresh), .light_valid(light_valid),
      .light_result(light_result), .light_lo_thresh(light_lo_thresh),
      .light_hi_thresh(light_hi_thresh),
      .prox_irq_enable(prox_irq_enable),
      .light_irq_enable(light_irq_enable),
      .prox_irq_clear(prox_irq_clear),
      .light_irq_clear(light_irq_clear), .prox_irq_flag(prox_irq_flag),
      .light_irq_flag(light_irq_flag), .int_n(int_n),
      .wait_period_count(wait_period_count), .wait_start(wait_start),
      .wait_done(wait_done), .emitter_pulse_length(emitter_pulse_length),
      .pulse_start(pulse_start), .emitter_on(emitter_on));

   host_model u_host_model (
      .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // clock
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         print_verdict();
      end
   end

   // one result pulse on either channel
   task automatic send(input bit lt, input logic [15:0] v);
      @(posedge sys_clk);
      if (lt) begin
         light_valid <= 1'b1;
         light_result <= v;
      end else begin
         prox_valid <= 1'b1;
         prox_result <= v[13:0];
      end
      @(posedge sys_clk);
      light_valid <= 1'b0;
      prox_valid <= 1'b0;
      #1;
   endtask

   function automatic logic flag(input bit lt);
      return lt ? light_irq_flag : prox_irq_flag;
   endfunction

   task automatic clr;
      @(posedge sys_clk);
      prox_irq_clear <= 1'b1;
      light_irq_clear <= 1'b1;
      @(posedge sys_clk);
      prox_irq_clear <= 1'b0;
      light_irq_clear <= 1'b0;
      #1;
   endtask

   // one persistence code: count, clear by in-range, fire, saturate
   task automatic run_code(input bit lt, input logic [3:0] code);
      int n;
      logic [15:0] o, i;
      n = (lt && code > 4'h3) ? 5 * (int'(code) - 3) : int'(code);
      o = lt ? (code[0] ? 16'h2000 : 16'h0010)
             : (code[0] ? 16'h0111 : 16'h0004);
      i = lt ? 16'h0800 : 16'h0080;
      u_host_model.wr(prox_pkg::ADDR_PERSISTENCE_FILTERS, lt ? {4'h0, code} : {code, 4'h0});
      light_irq_enable <= lt && code[0];
      send(lt, i);
      if (n == 0) begin
         check(16'(flag(lt)), 16'h0001);
         clr();
         return;
      end
      clr();
      if (n > 1) begin
         send(lt, o);
         send(lt, i);
      end
      repeat (n - 1) send(lt, o);
      check(16'(flag(lt)), 16'h0000);
      send(lt, o);
      check(16'(flag(lt)), 16'h0001);
      check(16'(int_n), 16'(lt && !code[0]));
      clr();
      send(lt, o);
      check(16'(flag(lt)), 16'h0001);
      clr();
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      auto_pulse_off = 1'b0;
      prox_valid = 1'b0;
      light_valid = 1'b0;
      prox_result = 14'h0000;
      light_result = 16'h0000;
      prox_lo_thresh = 14'h0008;
      light_lo_thresh = 16'h0100;
      light_hi_thresh = 16'h1000;
      prox_irq_clear = 1'b0;
      light_irq_clear = 1'b0;
      prox_irq_enable = 1'b1;
      light_irq_enable = 1'b0;
      wait_period_count = 8'h00;
      wait_start = 1'b0;
      emitter_pulse_length = 2'h0;
      pulse_start = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset values, unmapped write and read
      u_host_model.wr(8'h90, 8'hFF);
      u_host_model.rd(prox_pkg::ADDR_PHT_LO, d);
      check(16'(d), 16'(prox_pkg::RST_PHT_LO));
      u_host_model.rd(prox_pkg::ADDR_PHT_HI, d);
      check(16'(d), 16'(prox_pkg::RST_PHT_HI));
      u_host_model.rd(prox_pkg::ADDR_PERSISTENCE_FILTERS, d);
      check(16'(d), 16'(prox_pkg::RST_PERSISTENCE_FILTERS));
      u_host_model.rd(prox_pkg::ADDR_GENERAL_CONFIG_ZERO, d);
      check(16'(d), 16'(prox_pkg::RST_GENERAL_CONFIG_ZERO));
      u_host_model.rd(8'h90, d);
      check(16'(d), 16'(prox_pkg::RD_NONE));
      $display("test registers done");
      // threshold 0x0110, then every code on both channels
      u_host_model.wr_thresh(8'h10, 6'h01);
      u_host_model.rd(prox_pkg::ADDR_PHT_HI, d);
      check(16'(d), 16'h0001);
      for (int lt = 0; lt < 2; lt++)
         for (int c = 0; c < 16; c++)
            run_code(lt[0], 4'(c));
      $display("test persistence done");
      // shadow byte stays out of the compare until the upper write
      u_host_model.wr(prox_pkg::ADDR_PERSISTENCE_FILTERS, 8'h10);
      u_host_model.wr(prox_pkg::ADDR_PHT_LO, 8'hFF);
      send(0, 16'h0080);
      clr();
      send(0, 16'h0112);
      check(16'(prox_irq_flag), 16'h0001);
      clr();
      u_host_model.wr(prox_pkg::ADDR_PHT_HI, 8'h01);
      send(0, 16'h0112);
      check(16'(prox_irq_flag), 16'h0000);
      $display("test shadow done");
      // 10-bit mode: low byte against result bits 9:2, upper ignored
      u_host_model.wr_thresh(8'h10, 6'h3F);
      @(posedge sys_clk);
      auto_pulse_off <= 1'b1;
      send(0, 16'h0040);
      clr();
      send(0, 16'h0040);
      check(16'(prox_irq_flag), 16'h0000);
      send(0, 16'h0044);
      check(16'(prox_irq_flag), 16'h0001);
      clr();
      // enable low: flag sets but the pin stays idle
      @(posedge sys_clk);
      prox_irq_enable <= 1'b0;
      send(0, 16'h0044);
      check(16'(prox_irq_flag), 16'h0001);
      check(16'(int_n), 16'h0001);
      clr();
      @(posedge sys_clk);
      prox_irq_enable <= 1'b1;
      auto_pulse_off <= 1'b0;
      $display("test short compare done");
      // wait timer, plain and long
      for (int lg = 0; lg < 2; lg++) begin
         u_host_model.wr_general_config_zero(lg[0], 1'b0);
         @(posedge sys_clk);
         wait_period_count <= 8'h01;
         wait_start <= 1'b1;
         @(posedge sys_clk);
         wait_start <= 1'b0;
         k = 0;
         do begin
            @(posedge sys_clk);
            #1;
            k++;
         end while (wait_done !== 1'b1 && k < 2000);
         check(16'(k), 16'((lg ? 24 : 2) * TICK));
      end
      $display("test wait done");
      // emitter pulse lengths, last one stretched
      for (int c = 0; c < 5; c++) begin
         u_host_model.wr_general_config_zero(1'b0, c == 4);
         @(posedge sys_clk);
         emitter_pulse_length <= (c == 4) ? 2'h0 : 2'(c);
         pulse_start <= 1'b1;
         @(posedge sys_clk);
         pulse_start <= 1'b0;
         #1;
         w = 0;
         while (emitter_on !== 1'b1 && w < 3) begin
            @(posedge sys_clk);
            #1;
            w++;
         end
         k = 0;
         while (emitter_on === 1'b1 && k < 8000) begin
            @(posedge sys_clk);
            #1;
            k++;
         end
         check(16'(k), 16'(prox_pkg::PULSE_BASE_CYC << c));
      end
      $display("test pulse done");
      print_verdict();
   end
endmodule

`default_nettype wire
